// *** hw/mil_top.sv ***
// Interrupt generation, blanking, low-g debounce and wake-up cycle
`timescale 1ns/10ps

module mil_top (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Acceleration samples
	input wire logic smp_in,
	input wire logic z_done_in,
	input wire logic bw_smp_in,
	input wire mil_pkg::mil_accel_s accel_raw_in,
	input wire mil_pkg::mil_accel_s accel_filt_in,
	input wire logic data_read_in,
	input wire logic [3:0] filter_bandwidth_in,
	// Other detector criteria
	input wire logic high_crit_in,
	input wire logic slope_crit_in,
	input wire logic tap_crit_in,
	input wire logic [7:0] slope_dur_in,
	// Configuration
	input wire mil_pkg::mil_under_cfg_s under_cfg_in,
	input wire logic irq_latch_en_in,
	input wire logic irq_clear_in,
	input wire logic fresh_sample_irq_en_in,
	input wire logic sample_decimate_in,
	input wire logic high_irq_en_in,
	input wire logic tap_irq_en_in,
	input wire logic advanced_int_unlock_in,
	input wire logic motion_alert_en_in,
	input wire logic motion_irq_en_in,
	input wire logic damping_select_in,
	input wire logic wake_up_en_in,
	input wire logic [1:0] wake_up_dur_in,
	input wire logic low_power_in,
	input wire logic twowire_disable_in,
	input wire logic chip_select_n_in,
	input wire logic user_wr_in,
	input wire logic [15:0] user_data_in,
	// Status and pad
	output logic irq_pad_out,
	output logic [2:0] under_sign_flag_out,
	output logic under_flag_out,
	output logic fresh_flag_out,
	output logic alert_out,
	output logic damping_out,
	output logic twowire_active_out,
	output logic sleeping_out,
	output logic [7:0] user_byte_one_out,
	output logic [7:0] user_byte_two_out
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	mil_pkg::mil_pwr_e pwr_q;
	mil_pkg::mil_accel_s under_src;
	logic [2:0] below;
	logic [2:0] sign;
	logic [2:0] blank_q;
	logic [3:0] bw_q;
	logic blank_thr;
	logic blank_slope;
	logic [15:0] step_cnt_q;
	logic deb_step;
	logic [2:0] deb_div_q;
	logic [7:0] under_cnt_q;
	logic under_crit;
	logic under_fire;
	logic [1:0] dec_q;
	logic fresh_evt;
	logic valid_q;
	logic under_lat_q;
	logic high_lat_q;
	logic slope_lat_q;
	logic tap_lat_q;
	logic slope_en;
	logic [7:0] slope_cnt_q;
	logic slope_ok;
	logic any_active;
	logic sleep_start;
	logic sleep_done;

	// ----------------------------------------------------------------
	// Blanking after reset, wake-up or bandwidth change
	// ----------------------------------------------------------------
	// Counts samples since restart; saturates at the slope need
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			blank_q <= mil_pkg::BLANK_RST;
			// Present setting, so leaving reset is not seen as a change
			bw_q <= filter_bandwidth_in;
		end else begin
			bw_q <= filter_bandwidth_in;
			if (bw_q != filter_bandwidth_in || sleep_done) begin
				blank_q <= mil_pkg::BLANK_RST;
			end else if (smp_in && pwr_q != mil_pkg::MIL_SLEEP &&
					blank_q < 3'(mil_pkg::BLANK_SLOPE)) begin
				blank_q <= blank_q + 3'h1;
			end
		end
	end
	assign blank_thr = blank_q < 3'(mil_pkg::BLANK_THR);
	assign blank_slope = blank_q < 3'(mil_pkg::BLANK_SLOPE);

	// ----------------------------------------------------------------
	// Low-g detector
	// ----------------------------------------------------------------
	// Filtered or raw data by selection
	assign under_src = under_cfg_in.filtered_sel ? accel_filt_in : accel_raw_in;

	mil_axis_under u_ax_x (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.smp_in(smp_in),
		.accel_in(under_src.x),
		.level_in(under_cfg_in.level),
		.hyst_in(under_cfg_in.hyst),
		.below_out(below[0]),
		.sign_out(sign[0])
	);
	mil_axis_under u_ax_y (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.smp_in(smp_in),
		.accel_in(under_src.y),
		.level_in(under_cfg_in.level),
		.hyst_in(under_cfg_in.hyst),
		.below_out(below[1]),
		.sign_out(sign[1])
	);
	mil_axis_under u_ax_z (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.smp_in(smp_in),
		.accel_in(under_src.z),
		.level_in(under_cfg_in.level),
		.hyst_in(under_cfg_in.hyst),
		.below_out(below[2]),
		.sign_out(sign[2])
	);

	// Disabled axes do not hold off the AND; none enabled means no criterion
	assign under_crit = under_cfg_in.en && (under_cfg_in.axis_en != 3'h0) &&
		(&(below | ~under_cfg_in.axis_en)) && !blank_thr;

	// Debounce step: five sample periods, fixed in time
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			deb_div_q <= 3'h0;
		end else if (smp_in) begin
			deb_div_q <= (deb_div_q == 3'(mil_pkg::DEB_SAMPLES - 1)) ? 3'h0 :
				deb_div_q + 3'h1;
		end
	end
	assign deb_step = smp_in && (deb_div_q == 3'(mil_pkg::DEB_SAMPLES - 1));

	// Zero duration fires at once, else at counter equal
	assign under_fire = under_crit && ((under_cfg_in.dur == 8'h00) ||
		(deb_step && under_cnt_q + 8'h01 == under_cfg_in.dur));

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			under_cnt_q <= 8'h00;
		end else if (under_fire) begin
			under_cnt_q <= 8'h00;
		end else if (deb_step) begin
			if (under_crit) begin
				under_cnt_q <= under_cnt_q + 8'h01;
			end else begin
				case (under_cfg_in.countdown_rate)
					2'b00: under_cnt_q <= 8'h00;
					default: begin
						if (under_cnt_q > {6'h00, under_cfg_in.countdown_rate}) begin
							under_cnt_q <= under_cnt_q - {6'h00, under_cfg_in.countdown_rate};
						end else begin
							under_cnt_q <= 8'h00;
						end
					end
				endcase
			end
		end
	end

	// Sign kept only for enabled axes
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			under_sign_flag_out <= 3'h0;
		end else if (under_fire) begin
			under_sign_flag_out <= sign & under_cfg_in.axis_en;
		end else if (irq_clear_in) begin
			under_sign_flag_out <= 3'h0;
		end
	end

	// ----------------------------------------------------------------
	// Slope gating and advanced lock
	// ----------------------------------------------------------------
	// Advanced controls have no effect while locked
	assign slope_en = advanced_int_unlock_in && motion_irq_en_in;

	// Duration counted in bandwidth-derived sample ticks
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			slope_cnt_q <= 8'h00;
		end else if (!slope_crit_in || blank_slope) begin
			slope_cnt_q <= 8'h00;
		end else if (bw_smp_in && slope_cnt_q != 8'hFF) begin
			slope_cnt_q <= slope_cnt_q + 8'h01;
		end
	end
	assign slope_ok = slope_crit_in && !blank_slope && slope_cnt_q >= slope_dur_in;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			alert_out <= 1'b0;
			damping_out <= 1'b0;
		end else begin
			alert_out <= advanced_int_unlock_in && motion_alert_en_in && slope_ok;
			damping_out <= advanced_int_unlock_in && damping_select_in;
		end
	end

	// ----------------------------------------------------------------
	// Latch handling of the motion sources
	// ----------------------------------------------------------------
	// Set wins over a simultaneous clear
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			under_lat_q <= 1'b0;
			high_lat_q <= 1'b0;
			slope_lat_q <= 1'b0;
			tap_lat_q <= 1'b0;
		end else if (irq_latch_en_in) begin
			under_lat_q <= under_fire || (under_lat_q && !irq_clear_in);
			high_lat_q <= (high_irq_en_in && high_crit_in && !blank_thr) ||
				(high_lat_q && !irq_clear_in);
			slope_lat_q <= (slope_en && slope_ok) || (slope_lat_q && !irq_clear_in);
			tap_lat_q <= (tap_irq_en_in && tap_crit_in && !blank_slope) ||
				(tap_lat_q && !irq_clear_in);
		end else begin
			// Non-latched: held from fire until criterion drops
			under_lat_q <= under_fire || (under_lat_q && under_crit);
			high_lat_q <= high_irq_en_in && high_crit_in && !blank_thr;
			slope_lat_q <= slope_en && slope_ok;
			tap_lat_q <= tap_irq_en_in && tap_crit_in && !blank_slope;
		end
	end

	// ----------------------------------------------------------------
	// New-data interrupt
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			dec_q <= 2'h0;
			valid_q <= 1'b0;
		end else begin
			if (z_done_in) begin
				valid_q <= 1'b1;
			end
			if (z_done_in) begin
				dec_q <= 2'h0;
			end else if (bw_smp_in) begin
				dec_q <= 2'h1;
			end
		end
	end
	// Every Z update, or only the first after a bandwidth tick
	assign fresh_evt = z_done_in && (!sample_decimate_in || bw_smp_in || dec_q != 2'h0);

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			fresh_flag_out <= 1'b0;
		end else if (fresh_sample_irq_en_in && fresh_evt && (valid_q || z_done_in)) begin
			fresh_flag_out <= 1'b1;
		end else if (irq_clear_in || data_read_in || !fresh_sample_irq_en_in) begin
			fresh_flag_out <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Pad and status
	// ----------------------------------------------------------------
	assign any_active = under_lat_q || high_lat_q || slope_lat_q || tap_lat_q;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			irq_pad_out <= 1'b0;
			under_flag_out <= 1'b0;
		end else begin
			irq_pad_out <= any_active || fresh_flag_out;
			under_flag_out <= under_lat_q;
		end
	end

	// ----------------------------------------------------------------
	// Serial interface selection and user bytes
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			twowire_active_out <= 1'b0;
		end else begin
			twowire_active_out <= !twowire_disable_in && chip_select_n_in;
		end
	end

	// Stored only; nothing else reads them
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			user_byte_one_out <= 8'h00;
			user_byte_two_out <= 8'h00;
		end else if (user_wr_in) begin
			user_byte_one_out <= user_data_in[7:0];
			user_byte_two_out <= user_data_in[15:8];
		end
	end

	// ----------------------------------------------------------------
	// Sleep and wake-up cycle
	// ----------------------------------------------------------------
	// Sleep only once blanking is over and nothing is pending; a
	// latched source keeps the device awake until cleared.
	assign sleep_start = wake_up_en_in && pwr_q == mil_pkg::MIL_RUN &&
		!blank_slope && !any_active && !fresh_flag_out;

	mil_sleep_timer u_sleep (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.start_in(sleep_start),
		.smp_in(smp_in),
		.dur_sel_in(wake_up_dur_in),
		.low_power_in(low_power_in),
		.done_out(sleep_done)
	);

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			pwr_q <= mil_pkg::MIL_RUN;
			sleeping_out <= 1'b0;
		end else begin
			case (pwr_q)
				mil_pkg::MIL_RUN: begin
					if (sleep_start) begin
						pwr_q <= mil_pkg::MIL_SLEEP;
						sleeping_out <= 1'b1;
					end
				end
				mil_pkg::MIL_SLEEP: begin
					if (sleep_done || !wake_up_en_in) begin
						pwr_q <= mil_pkg::MIL_RUN;
						sleeping_out <= 1'b0;
					end
				end
				default: begin
					pwr_q <= mil_pkg::MIL_RUN;
					sleeping_out <= 1'b0;
				end
			endcase
		end
	end
endmodule // mil_top

// *** pkg/mil_pkg.sv ***
// Package for the motion interrupt logic: constants and carrier structs
package mil_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 40000000;
	// One sample period is 417 us; five of them are one debounce step
	localparam int unsigned SAMPLE_NS = 417000;
	localparam int unsigned SAMPLE_CYC = (SAMPLE_NS * 40) / 1000;
	localparam int unsigned DEB_SAMPLES = 5;
	localparam int unsigned SLEEP_MS_0 = 20;
	localparam int unsigned SLEEP_MS_1 = 80;
	localparam int unsigned SLEEP_MS_2 = 320;
	localparam int unsigned SLEEP_MS_3 = 2560;
	// Sleep interval counted in sample periods (rounded down)
	localparam int unsigned SLEEP_SMP_0 = (SLEEP_MS_0 * 1000000) / SAMPLE_NS;
	localparam int unsigned SLEEP_SMP_1 = (SLEEP_MS_1 * 1000000) / SAMPLE_NS;
	localparam int unsigned SLEEP_SMP_2 = (SLEEP_MS_2 * 1000000) / SAMPLE_NS;
	localparam int unsigned SLEEP_SMP_3 = (SLEEP_MS_3 * 1000000) / SAMPLE_NS;
	localparam int unsigned BLANK_THR = 1;
	localparam int unsigned BLANK_SLOPE = 4;
	localparam logic [2:0] BLANK_RST = 3'h0;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [13:0] x;
		logic [13:0] y;
		logic [13:0] z;
	} mil_accel_s;

	typedef struct packed {
		logic en;
		logic [2:0] axis_en;
		logic filtered_sel;
		logic [7:0] level;
		logic [7:0] hyst;
		logic [7:0] dur;
		logic [1:0] countdown_rate;
	} mil_under_cfg_s;

	typedef enum logic [1:0] {
		MIL_RUN = 2'b00,
		MIL_SLEEP = 2'b01,
		MIL_HOLD = 2'b10
	} mil_pwr_e;

endpackage

// *** hw/mil_axis_under.sv ***
// Per-axis low threshold comparator with hysteresis and sign capture
`timescale 1ns/10ps
module mil_axis_under (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Sample
	input wire logic smp_in,
	input wire logic [13:0] accel_in,
	input wire logic [7:0] level_in,
	input wire logic [7:0] hyst_in,
	// Result
	output logic below_out,
	output logic sign_out
);
	logic [13:0] mag;
	logic [8:0] upper;
	logic below_q;
	logic sign_q;

	assign mag = accel_in[13] ? 14'(~accel_in + 14'h1) : accel_in;
	assign upper = {1'b0, level_in} + {1'b0, hyst_in};
	assign sign_out = sign_q;
	assign below_out = below_q;

	// Enter below level, leave only above level plus hysteresis
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			below_q <= 1'b0;
			sign_q <= 1'b0;
		end else if (smp_in) begin
			// Sign taken from the sample that the comparison judged
			sign_q <= accel_in[13];
			if (!below_q) begin
				below_q <= (mag[13:6] < level_in);
			end else begin
				below_q <= ({1'b0, mag[13:6]} <= upper);
			end
		end
	end
endmodule // mil_axis_under

// *** hw/mil_sleep_timer.sv ***
// Sleep interval timer counted in sample periods
`timescale 1ns/10ps
module mil_sleep_timer (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Control
	input wire logic start_in,
	input wire logic smp_in,
	input wire logic [1:0] dur_sel_in,
	input wire logic low_power_in,
	// Result
	output logic done_out
);
	logic [15:0] cnt_q;
	logic [15:0] len;
	logic run_q;

	// Interval per field, doubled in low-power mode
	always_comb begin
		case (dur_sel_in)
			2'b00: len = 16'(mil_pkg::SLEEP_SMP_0);
			2'b01: len = 16'(mil_pkg::SLEEP_SMP_1);
			2'b10: len = 16'(mil_pkg::SLEEP_SMP_2);
			default: len = 16'(mil_pkg::SLEEP_SMP_3);
		endcase
		if (low_power_in) begin
			len = {len[14:0], 1'b0};
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			cnt_q <= 16'h0000;
			run_q <= 1'b0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (start_in) begin
				cnt_q <= 16'h0000;
				run_q <= 1'b1;
			end else if (run_q && smp_in) begin
				if (cnt_q + 16'h0001 >= len) begin
					run_q <= 1'b0;
					done_out <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 16'h0001;
				end
			end
		end
	end
endmodule // mil_sleep_timer

// *** tb/mil_top_asserts.sv ***
// Port-level assertions for the motion interrupt logic
`timescale 1ns/10ps
module mil_top_asserts (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Inputs
	input wire logic z_done_in,
	input wire logic data_read_in,
	input wire logic irq_clear_in,
	input wire mil_pkg::mil_under_cfg_s under_cfg_in,
	input wire logic advanced_int_unlock_in,
	input wire logic damping_select_in,
	input wire logic twowire_disable_in,
	input wire logic chip_select_n_in,
	// Outputs
	input wire logic irq_pad_out,
	input wire logic [2:0] under_sign_flag_out,
	input wire logic under_flag_out,
	input wire logic fresh_flag_out,
	input wire logic alert_out,
	input wire logic damping_out,
	input wire logic twowire_active_out
);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);

	AST_TWOWIRE: assert property (
		!$past(rst_in) |->
		twowire_active_out == (!$past(twowire_disable_in) && $past(chip_select_n_in)))
		else $error("Two-wire status wrong");
	AST_DAMP_LOCK: assert property (
		!$past(rst_in) |-> damping_out == $past(advanced_int_unlock_in && damping_select_in))
		else $error("Damping select not gated");
	AST_ALERT_LOCK: assert property (
		!$past(advanced_int_unlock_in) |-> !alert_out)
		else $error("Alert while locked");
	AST_FRESH_CAUSE: assert property (
		$rose(fresh_flag_out) |-> $past(z_done_in))
		else $error("New-data flag without Z update");
	AST_FRESH_CLEAR: assert property (
		$past(irq_clear_in || data_read_in) && !$past(z_done_in) |-> !fresh_flag_out)
		else $error("New-data flag not cleared");
	AST_PAD_FRESH: assert property (
		$past(fresh_flag_out) && !$past(rst_in) |-> irq_pad_out)
		else $error("Pad low with new-data pending");
	AST_PAD_UNDER: assert property (
		under_flag_out |-> irq_pad_out)
		else $error("Pad low with low-g flag");
	AST_SIGN_MASK: assert property (
		$rose(under_flag_out) |-> (under_sign_flag_out & ~$past(under_cfg_in.axis_en, 2)) == 3'h0)
		else $error("Sign stored for disabled axis");
endmodule // mil_top_asserts

bind mil_top mil_top_asserts u_chk (.mclk_in(mclk_in), .rst_in(rst_in), .z_done_in(z_done_in),
	.data_read_in(data_read_in), .irq_clear_in(irq_clear_in), .under_cfg_in(under_cfg_in),
	.advanced_int_unlock_in(advanced_int_unlock_in), .damping_select_in(damping_select_in),
	.twowire_disable_in(twowire_disable_in), .chip_select_n_in(chip_select_n_in),
	.irq_pad_out(irq_pad_out), .under_sign_flag_out(under_sign_flag_out),
	.under_flag_out(under_flag_out), .fresh_flag_out(fresh_flag_out), .alert_out(alert_out),
	.damping_out(damping_out), .twowire_active_out(twowire_active_out));

// *** tb/mil_host_model.sv ***
// Host microcontroller model: services the pad, sets interface and duration options
`timescale 1ns/10ps
module mil_host_model (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Bench controls
	input wire logic service_en_in,
	input wire logic spi_mode_in,
	input wire logic motion_used_in,
	input wire logic [3:0] wait_in,
	// Pad
	input wire logic irq_pad_in,
	// Towards the block
	output logic twowire_disable_out,
	output logic [7:0] slope_dur_out,
	output logic data_read_out,
	output logic irq_clear_out
);
	logic [4:0] cnt_q;
	// An SPI host keeps two-wire decoding off so stray traffic cannot confuse it
	assign twowire_disable_out = spi_mode_in;
	assign slope_dur_out = motion_used_in ? 8'h02 : 8'h00;
	always_ff @(posedge mclk_in) begin
		if (rst_in || !service_en_in || (!irq_pad_in && cnt_q == 5'h00)) begin
			cnt_q <= 5'h00;
		end else begin
			cnt_q <= cnt_q + 5'h01;
		end
	end
	// Read the data first, then write the clear only if the pad is still up
	always_ff @(posedge mclk_in) begin
		data_read_out <= !rst_in && service_en_in && cnt_q == {1'b0, wait_in};
		irq_clear_out <= !rst_in && service_en_in && irq_pad_in &&
			cnt_q == {1'b0, wait_in} + 5'h04;
	end
endmodule // mil_host_model

// *** tb/mil_top_tb.sv ***
// Self-checking bench for the motion interrupt logic
`timescale 1ns/10ps
module mil_top_tb;
	logic mclk_in, rst_in, smp_in, z_done_in, bw_smp_in, high_crit_in, slope_crit_in, tap_crit_in;
	logic irq_latch_en_in, tb_clear, fresh_sample_irq_en_in, sample_decimate_in, high_irq_en_in;
	logic tap_irq_en_in, advanced_int_unlock_in, motion_alert_en_in, motion_irq_en_in;
	logic damping_select_in, wake_up_en_in, low_power_in, chip_select_n_in, user_wr_in;
	logic service_en, spi_mode, irq_clear_in, data_read_in, twowire_disable_in, host_clear;
	logic irq_pad_out, under_flag_out, fresh_flag_out, alert_out, damping_out;
	logic twowire_active_out, sleeping_out;
	logic [1:0] wake_up_dur_in;
	logic [2:0] under_sign_flag_out;
	logic [3:0] filter_bandwidth_in, wait_cyc;
	logic [7:0] slope_dur_in, user_byte_one_out, user_byte_two_out;
	logic [13:0] big;
	logic [15:0] user_data_in;
	mil_pkg::mil_accel_s accel_raw_in, accel_filt_in;
	mil_pkg::mil_under_cfg_s ucfg;
	int n_mismatch, checked, seed, i, j, n;
	assign irq_clear_in = host_clear | tb_clear;

	mil_top DUT (.mclk_in(mclk_in), .rst_in(rst_in), .smp_in(smp_in), .z_done_in(z_done_in),
		.bw_smp_in(bw_smp_in), .accel_raw_in(accel_raw_in), .accel_filt_in(accel_filt_in),
		.data_read_in(data_read_in), .filter_bandwidth_in(filter_bandwidth_in),
		.high_crit_in(high_crit_in), .slope_crit_in(slope_crit_in), .tap_crit_in(tap_crit_in),
		.slope_dur_in(slope_dur_in), .under_cfg_in(ucfg), .irq_latch_en_in(irq_latch_en_in),
		.irq_clear_in(irq_clear_in), .fresh_sample_irq_en_in(fresh_sample_irq_en_in),
		.sample_decimate_in(sample_decimate_in), .high_irq_en_in(high_irq_en_in),
		.tap_irq_en_in(tap_irq_en_in), .advanced_int_unlock_in(advanced_int_unlock_in),
		.motion_alert_en_in(motion_alert_en_in), .motion_irq_en_in(motion_irq_en_in),
		.damping_select_in(damping_select_in), .wake_up_en_in(wake_up_en_in),
		.wake_up_dur_in(wake_up_dur_in), .low_power_in(low_power_in),
		.twowire_disable_in(twowire_disable_in), .chip_select_n_in(chip_select_n_in),
		.user_wr_in(user_wr_in), .user_data_in(user_data_in), .irq_pad_out(irq_pad_out),
		.under_sign_flag_out(under_sign_flag_out), .under_flag_out(under_flag_out),
		.fresh_flag_out(fresh_flag_out), .alert_out(alert_out), .damping_out(damping_out),
		.twowire_active_out(twowire_active_out), .sleeping_out(sleeping_out),
		.user_byte_one_out(user_byte_one_out), .user_byte_two_out(user_byte_two_out));
	mil_host_model host (.mclk_in(mclk_in), .rst_in(rst_in), .service_en_in(service_en),
		.spi_mode_in(spi_mode), .motion_used_in(motion_alert_en_in), .wait_in(wait_cyc),
		.irq_pad_in(irq_pad_out), .twowire_disable_out(twowire_disable_in),
		.slope_dur_out(slope_dur_in), .data_read_out(data_read_in), .irq_clear_out(host_clear));

	// --------
	// Helpers
	// --------
	initial begin
		mclk_in = 1'b0;
		forever #12.5 mclk_in = ~mclk_in;
	end
	task automatic tick(input int k);
		repeat (k) @(negedge mclk_in);
	endtask
	task automatic smp(input int k);
		repeat (k) begin
			{smp_in, bw_smp_in} = 2'h3;
			tick(1);
			{smp_in, bw_smp_in} = 2'h0;
			tick(3);
		end
	endtask
	// One-cycle strobe: 0 clear, 1 Z update, 2 bandwidth tick, 3 user write
	task automatic pulse(input int s);
		{tb_clear, z_done_in, bw_smp_in, user_wr_in} = 4'h8 >> s;
		tick(1);
		{tb_clear, z_done_in, bw_smp_in, user_wr_in} = 4'h0;
		tick(2);
	endtask
	task automatic acc(input logic [13:0] x, input logic [13:0] y, input logic [13:0] z);
		accel_raw_in = {x, y, z};
		accel_filt_in = {x, y, z};
	endtask
	// Magnitude stays under 512, so its top eight bits stay under 8
	function automatic logic [13:0] lo(input logic neg);
		lo = (14'($random(seed)) & 14'h01FF) | 14'h0001;
		if (neg)
			lo = -lo;
	endfunction
	function automatic int sleep_smp(input logic [1:0] s, input logic lp);
		longint ms;
		ms = (s == 2'h0) ? 20 : (s == 2'h1) ? 80 : (s == 2'h2) ? 320 : 2560;
		return int'((ms * 1000000) / mil_pkg::SAMPLE_NS) << lp;
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic test_done();
		if (n_mismatch == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		#(25 * 60000);
		n_mismatch++;
		test_done();
	end

	// --------
	// Scenarios
	// --------
	initial begin
		{seed, n_mismatch, checked, big} = {32'd97990, 64'd0, 14'h1000};
		{smp_in, z_done_in, bw_smp_in, high_crit_in, slope_crit_in, tap_crit_in, tb_clear,
			irq_latch_en_in, fresh_sample_irq_en_in, sample_decimate_in, high_irq_en_in,
			tap_irq_en_in, advanced_int_unlock_in, motion_alert_en_in, motion_irq_en_in,
			damping_select_in, wake_up_en_in, low_power_in, user_wr_in, service_en} = '0;
		{spi_mode, chip_select_n_in, wake_up_dur_in, filter_bandwidth_in, wait_cyc} = 12'h470;
		{user_data_in, ucfg} = '0;
		acc(big, big, big);
		rst_in = 1'b1;
		tick(20);
		rst_in = 1'b0;
		smp(5);
		for (i = 0; i < 16; i++) begin
			{spi_mode, chip_select_n_in, advanced_int_unlock_in, damping_select_in} = 4'($random(seed));
			user_data_in = 16'($random(seed));
			pulse(3);
			chk("twowire", 16'(!spi_mode && chip_select_n_in), 16'(twowire_active_out));
			chk("damping", 16'(advanced_int_unlock_in && damping_select_in), 16'(damping_out));
			chk("user", user_data_in, {user_byte_two_out, user_byte_one_out});
		end
		{chip_select_n_in, advanced_int_unlock_in, motion_alert_en_in, motion_irq_en_in} = 4'hB;
		slope_crit_in = 1'b1;
		smp(5);
		chk("alert lock", 16'h0, {alert_out, irq_pad_out});
		{advanced_int_unlock_in, motion_irq_en_in} = 2'h2;
		smp(4);
		chk("alert", 16'h1, 16'(alert_out));
		{advanced_int_unlock_in, motion_alert_en_in, slope_crit_in, high_irq_en_in} = 4'h1;
		high_crit_in = 1'b1;
		smp(1);
		chk("high pad", 16'h1, 16'(irq_pad_out));
		filter_bandwidth_in = 4'h3;
		tick(6);
		chk("blank thr", 16'h0, 16'(irq_pad_out));
		smp(1);
		chk("high pad", 16'h1, 16'(irq_pad_out));
		{high_crit_in, high_irq_en_in, tap_irq_en_in, tap_crit_in} = 4'h3;
		filter_bandwidth_in = 4'h7;
		tick(1);
		smp(3);
		chk("blank tap", 16'h0, 16'(irq_pad_out));
		smp(1);
		chk("tap pad", 16'h1, 16'(irq_pad_out));
		tap_crit_in = 1'b0;
		tick(4);
		chk("tap drop", 16'h0, 16'(irq_pad_out));
		irq_latch_en_in = 1'b1;
		tap_crit_in = 1'b1;
		tick(4);
		tap_crit_in = 1'b0;
		tick(4);
		chk("tap latch", 16'h1, 16'(irq_pad_out));
		pulse(0);
		chk("tap clear", 16'h0, 16'(irq_pad_out));
		{tap_irq_en_in, fresh_sample_irq_en_in} = 2'h1;
		for (i = 0; i < 4; i++) begin
			sample_decimate_in = i[1];
			if (!i[0])
				pulse(2);
			pulse(1);
			chk("fresh", 16'(!i[1] || !i[0]), {fresh_flag_out, irq_pad_out} == 2'h3);
			pulse(0);
			chk("fresh clr", 16'h0, 16'(fresh_flag_out));
		end
		{sample_decimate_in, service_en} = 2'h1;
		for (i = 0; i < 4; i++) begin
			wait_cyc = (i == 0) ? 4'h0 : 4'($random(seed));
			pulse(1);
			for (j = 0; j < 60 && {fresh_flag_out, irq_pad_out} !== 2'h0; j++)
				tick(1);
			chk("serviced", 16'h0, {fresh_flag_out, irq_pad_out});
		end
		{service_en, fresh_sample_irq_en_in} = 2'h0;
		ucfg = '{1'b1, 3'h7, 1'b1, 8'h08, 8'h04, 8'h00, 2'h0};
		for (i = 0; i < 8; i++) begin
			n = $random(seed);
			ucfg.axis_en = 3'(i);
			acc(i[0] ? lo(n[0]) : big, i[1] ? lo(n[1]) : big, i[2] ? lo(n[2]) : big);
			smp(1);
			chk("under", 16'(i != 0), 16'(under_flag_out));
			chk("sign", 16'(n[2:0] & 3'(i)), 16'(under_sign_flag_out));
			acc(big, big, big);
			smp(1);
			chk("latched", 16'(i != 0), 16'(irq_pad_out));
			pulse(0);
			chk("clear", 16'h0, {under_flag_out, irq_pad_out, under_sign_flag_out});
		end
		ucfg.axis_en = 3'h7;
		for (i = 0; i < 2; i++) begin
			ucfg.filtered_sel = i[0];
			accel_filt_in = {lo(0), lo(1), lo(0)};
			smp(1);
			chk("filt sel", 16'(i[0]), 16'(under_flag_out));
			pulse(0);
		end
		irq_latch_en_in = 1'b0;
		acc(14'h01FF, 14'h3E01, 14'h01FF);
		smp(1);
		chk("nonlatch", 16'h1, 16'(irq_pad_out));
		acc(14'h0280, 14'h3D80, 14'h0280);
		smp(1);
		chk("hyst hold", 16'h1, 16'(under_flag_out));
		acc(14'h0280, 14'h0340, 14'h0280);
		smp(1);
		chk("hyst drop", 16'h0, {under_flag_out, irq_pad_out});
		acc(14'h0200, 14'h0280, 14'h0200);
		smp(1);
		chk("no entry", 16'h0, 16'(under_flag_out));
		{irq_latch_en_in, ucfg.dur} = {1'b1, 8'h04};
		for (i = 0; i < 4; i++) begin
			ucfg.countdown_rate = 2'(i);
			acc(lo(0), lo(1), lo(0));
			smp(10);
			acc(big, big, big);
			smp(5);
			acc(lo(1), lo(0), lo(0));
			smp(15);
			chk("countdown", 16'(i == 1), 16'(under_flag_out));
			smp(10);
			chk("debounce", 16'h1, 16'(under_flag_out));
			acc(big, big, big);
			ucfg.countdown_rate = 2'h0;
			smp(5);
			pulse(0);
		end
		{ucfg.en, irq_latch_en_in} = 2'h0;
		for (i = 0; i < 4; i++) begin
			{wake_up_dur_in, low_power_in, wake_up_en_in} = {1'b0, i[1], i[0], 1'b1};
			smp(1);
			for (j = 0; j < 20 && sleeping_out !== 1'b1; j++)
				tick(1);
			chk("asleep", 16'h1, 16'(sleeping_out));
			for (n = 0; n < 500 && sleeping_out === 1'b1; n++)
				smp(1);
			chk("sleep len", 16'(sleep_smp(wake_up_dur_in, low_power_in)), 16'(n));
			wake_up_en_in = 1'b0;
			smp(4);
		end
		test_done();
	end
endmodule // mil_top_tb
